// ---- inc/dpio_defines.svh ----
`ifndef DPIO_DEFINES_SVH
`define DPIO_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define DPIO_IDX_PORT4_DATA    8'h08
`define DPIO_IDX_PORT4_DIR     8'h88
`define DPIO_IDX_PORT5_DIR     8'h89
`define DPIO_IDX_PORT5_DATA    8'h09
`define DPIO_IDX_ANALOG_CFG    8'h90
`define DPIO_IDX_HOST_OUT      8'h91
`define DPIO_IDX_HOST_IN       8'h92
`define DPIO_IDX_IRQ_STATUS    8'h93
`define DPIO_IDX_IRQ_MASK      8'h94

// Field positions of the fifth-port direction and host status register.
`define DPIO_F_INFULL          7
`define DPIO_F_OUTFULL         6
`define DPIO_F_OVERRUN         5
`define DPIO_F_HOSTMODE        4

// Reset values.
`define DPIO_RST_PORT4_DIR     8'hff
`define DPIO_RST_PORT5_DIR     3'h7
`define DPIO_RST_ANALOG        3'h7

// Interrupt status bits.
`define DPIO_IRQ_HOST_WR       0
`define DPIO_IRQ_HOST_RD       1
`define DPIO_IRQ_OVERRUN       2
`define DPIO_IRQ_BITS          3

`endif

// ---- inc/dpio_pkg.sv ----
package dpio_pkg;
	typedef enum logic [1:0] {
		DPIO_STB_IDLE = 2'b00,
		DPIO_STB_WR   = 2'b01,
		DPIO_STB_RD   = 2'b10
	} dpio_strobe_t;
endpackage

// ---- src/dpio_strobe_det.sv ----
`timescale 1ns/1ps
`include "dpio_defines.svh"
// Turns the host read and write strobes, each gated by chip select, into
// one-cycle pulses at the end of the strobe (rising edge of the low pulse).
module dpio_strobe_det
	import dpio_pkg::*;
(
	input  wire logic sys_clk_i,
	input  wire logic rst_i,
	input  wire logic enable_i,
	input  wire logic rd_n_i,
	input  wire logic wr_n_i,
	input  wire logic cs_n_i,
	output logic      rd_active_o,
	output logic      wr_done_o,
	output logic      rd_done_o
);
	dpio_strobe_t state;
	dpio_strobe_t next_state;

	always_comb begin
		next_state = state;
		wr_done_o  = 1'b0;
		rd_done_o  = 1'b0;
		case (state)
			DPIO_STB_IDLE: begin
				if (enable_i && !cs_n_i && !wr_n_i) begin
					next_state = DPIO_STB_WR;
				end else if (enable_i && !cs_n_i && !rd_n_i) begin
					next_state = DPIO_STB_RD;
				end
			end
			DPIO_STB_WR: begin
				if (!enable_i || cs_n_i || wr_n_i) begin
					next_state = DPIO_STB_IDLE;
					wr_done_o  = enable_i;
				end
			end
			DPIO_STB_RD: begin
				if (!enable_i || cs_n_i || rd_n_i) begin
					next_state = DPIO_STB_IDLE;
					rd_done_o  = enable_i;
				end
			end
			default: begin
				next_state = DPIO_STB_IDLE;
			end
		endcase
	end

	assign rd_active_o = enable_i && !cs_n_i && !rd_n_i;

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			state <= DPIO_STB_IDLE;
		end else begin
			state <= next_state;
		end
	end
endmodule

// ---- src/dpio_irq.sv ----
`timescale 1ns/1ps
`include "dpio_defines.svh"
// Sticky event bits, cleared by writing one; a new event wins over a clear.
module dpio_irq #(
	parameter int N = `DPIO_IRQ_BITS
) (
	input  wire logic         sys_clk_i,
	input  wire logic         rst_i,
	input  wire logic [N-1:0] event_i,
	input  wire logic [N-1:0] clear_i,
	input  wire logic [N-1:0] mask_i,
	output logic      [N-1:0] status_o,
	output logic              irq_o
);
	logic [N-1:0] next_status;

	always_comb begin
		next_status = (status_o & ~clear_i) | event_i;
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			status_o <= '0;
			irq_o    <= 1'b0;
		end else begin
			status_o <= next_status;
			irq_o    <= |(next_status & mask_i);
		end
	end
endmodule

// ---- src/dpio_top.sv ----
`timescale 1ns/1ps
`include "dpio_defines.svh"
// Function
// - Eight-pin port, each pin separately input or output.
// - Host mode bit makes the eight-pin port a byte-wide slave port.
// - Three-pin port, each pin separately input or output.
// - In host mode the three pins are read, write and select strobes.
// - Strobes only work when all three direction bits are inputs.
// - Strobes only work when the pins are configured digital.
// - A pin configured analog reads as zero.
// - Direction bits still drive the pins while they are analog.
// - After reset the three pins are analog inputs.
// - Eight-pin direction register resets to all ones.
module dpio_top
	import dpio_pkg::*;
#(
	parameter int W = 8
) (
	input  wire logic         sys_clk_i,
	input  wire logic         rst_i,
	input  wire logic         psel_i,
	input  wire logic         penable_i,
	input  wire logic         pwrite_i,
	input  wire logic [11:0]  paddr_i,
	input  wire logic [31:0]  pwdata_i,
	output logic      [31:0]  prdata_o,
	output logic              pready_o,
	output logic              pslverr_o,
	input  wire logic [W-1:0] port4_pins_i,
	output logic      [W-1:0] port4_pins_o,
	output logic      [W-1:0] port4_pins_oe_o,
	input  wire logic [2:0]   port5_pins_i,
	output logic      [2:0]   port5_pins_o,
	output logic      [2:0]   port5_pins_oe_o,
	output logic      [2:0]   analog_sel_o,
	output logic              irq_o
);
	logic [W-1:0] port4_latch;
	logic [W-1:0] port4_dir;
	logic [2:0]   port5_latch;
	logic [2:0]   port5_dir;
	logic [2:0]   analog_cfg;
	logic         host_mode;
	logic         in_full;
	logic         out_full;
	logic         overrun;
	logic [W-1:0] host_in;
	logic [W-1:0] host_out;
	logic [`DPIO_IRQ_BITS-1:0] irq_mask;
	logic [`DPIO_IRQ_BITS-1:0] irq_status;
	logic [`DPIO_IRQ_BITS-1:0] irq_clear;

	logic [W-1:0] next_port4_latch;
	logic [W-1:0] next_port4_dir;
	logic [2:0]   next_port5_latch;
	logic [2:0]   next_port5_dir;
	logic [2:0]   next_analog_cfg;
	logic         next_host_mode;
	logic         next_in_full;
	logic         next_out_full;
	logic         next_overrun;
	logic [W-1:0] next_host_in;
	logic [W-1:0] next_host_out;
	logic [`DPIO_IRQ_BITS-1:0] next_irq_mask;
	logic [31:0]  next_prdata;

	logic         host_en;
	logic         rd_active;
	logic         wr_done;
	logic         rd_done;
	logic [2:0]   port5_read;
	logic         wr_acc;
	logic         rd_acc;

	// Byte address of a register from its index.
	function automatic logic [11:0] reg_addr(input logic [7:0] idx);
		reg_addr = {2'b00, idx, 2'b00};
	endfunction

	function automatic logic hit(input logic [11:0] a, input logic [7:0] idx);
		hit = (a == reg_addr(idx));
	endfunction

	assign wr_acc    = psel_i && penable_i && pwrite_i;
	assign rd_acc    = psel_i && !penable_i && !pwrite_i;
	assign pready_o  = 1'b1;
	assign pslverr_o = 1'b0;

	// Strobes need host mode, all three pins inputs and digital.
	assign host_en = host_mode && (&port5_dir) && (analog_cfg == 3'h0);

	dpio_strobe_det u_strobe (
		.sys_clk_i   (sys_clk_i),
		.rst_i       (rst_i),
		.enable_i    (host_en),
		.rd_n_i      (port5_pins_i[0]),
		.wr_n_i      (port5_pins_i[1]),
		.cs_n_i      (port5_pins_i[2]),
		.rd_active_o (rd_active),
		.wr_done_o   (wr_done),
		.rd_done_o   (rd_done)
	);

	// Each pin is an input or output on its own; in host mode the eight pins
	// drive the outbound byte only while the host holds a read strobe.
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_port4
			assign port4_pins_o[g]    = host_mode ? host_out[g] : port4_latch[g];
			assign port4_pins_oe_o[g] = host_mode ? rd_active : !port4_dir[g];
		end
		for (g = 0; g < 3; g++) begin : g_port5
			assign port5_pins_o[g]    = port5_latch[g];
			assign port5_pins_oe_o[g] = !port5_dir[g];
			assign port5_read[g]      = analog_cfg[g] ? 1'b0 : port5_pins_i[g];
		end
	endgenerate

	assign analog_sel_o = analog_cfg;
	assign irq_clear    = (wr_acc && hit(paddr_i, `DPIO_IDX_IRQ_STATUS)) ?
		pwdata_i[`DPIO_IRQ_BITS-1:0] : '0;

	always_comb begin
		next_port4_latch = port4_latch;
		next_port4_dir   = port4_dir;
		next_port5_latch = port5_latch;
		next_port5_dir   = port5_dir;
		next_analog_cfg  = analog_cfg;
		next_host_mode   = host_mode;
		next_in_full     = in_full;
		next_out_full    = out_full;
		next_overrun     = overrun;
		next_host_in     = host_in;
		next_host_out    = host_out;
		next_irq_mask    = irq_mask;
		next_prdata      = prdata_o;
		if (wr_acc) begin
			if (hit(paddr_i, `DPIO_IDX_PORT4_DATA)) begin
				next_port4_latch = pwdata_i[W-1:0];
			end
			if (hit(paddr_i, `DPIO_IDX_PORT4_DIR)) begin
				next_port4_dir = pwdata_i[W-1:0];
			end
			if (hit(paddr_i, `DPIO_IDX_PORT5_DATA)) begin
				next_port5_latch = pwdata_i[2:0];
			end
			if (hit(paddr_i, `DPIO_IDX_PORT5_DIR)) begin
				next_port5_dir = pwdata_i[2:0];
				next_host_mode = pwdata_i[`DPIO_F_HOSTMODE];
				if (!pwdata_i[`DPIO_F_OVERRUN]) begin
					next_overrun = 1'b0;
				end
			end
			if (hit(paddr_i, `DPIO_IDX_ANALOG_CFG)) begin
				next_analog_cfg = pwdata_i[2:0];
			end
			if (hit(paddr_i, `DPIO_IDX_HOST_OUT)) begin
				next_host_out = pwdata_i[W-1:0];
				next_out_full = 1'b1;
			end
			if (hit(paddr_i, `DPIO_IDX_IRQ_MASK)) begin
				next_irq_mask = pwdata_i[`DPIO_IRQ_BITS-1:0];
			end
		end
		if (rd_acc) begin
			next_prdata = 32'h0000_0000;
			if (hit(paddr_i, `DPIO_IDX_PORT4_DATA)) begin
				next_prdata[W-1:0] = port4_pins_i;
			end
			if (hit(paddr_i, `DPIO_IDX_PORT4_DIR)) begin
				next_prdata[W-1:0] = port4_dir;
			end
			if (hit(paddr_i, `DPIO_IDX_PORT5_DATA)) begin
				next_prdata[2:0] = port5_read;
			end
			if (hit(paddr_i, `DPIO_IDX_PORT5_DIR)) begin
				next_prdata[7:0] = {in_full, out_full, overrun, host_mode, 1'b0,
					port5_dir};
			end
			if (hit(paddr_i, `DPIO_IDX_ANALOG_CFG)) begin
				next_prdata[2:0] = analog_cfg;
			end
			if (hit(paddr_i, `DPIO_IDX_HOST_OUT)) begin
				next_prdata[W-1:0] = host_out;
			end
			if (hit(paddr_i, `DPIO_IDX_HOST_IN)) begin
				next_prdata[W-1:0] = host_in;
				next_in_full       = 1'b0;
			end
			if (hit(paddr_i, `DPIO_IDX_IRQ_STATUS)) begin
				next_prdata[`DPIO_IRQ_BITS-1:0] = irq_status;
			end
			if (hit(paddr_i, `DPIO_IDX_IRQ_MASK)) begin
				next_prdata[`DPIO_IRQ_BITS-1:0] = irq_mask;
			end
		end
		// Host events come last so they win over a software clear in the same cycle.
		if (wr_done) begin
			next_host_in = port4_pins_i;
			next_in_full = 1'b1;
			if (in_full) begin
				next_overrun = 1'b1;
			end
		end
		// A new outbound byte written in the same cycle stays flagged, so set wins.
		if (rd_done && !(wr_acc && hit(paddr_i, `DPIO_IDX_HOST_OUT))) begin
			next_out_full = 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			port4_latch <= '0;
			port4_dir   <= `DPIO_RST_PORT4_DIR;
			port5_latch <= 3'h0;
			port5_dir   <= `DPIO_RST_PORT5_DIR;
			analog_cfg  <= `DPIO_RST_ANALOG;
			host_mode   <= 1'b0;
			in_full     <= 1'b0;
			out_full    <= 1'b0;
			overrun     <= 1'b0;
			host_in     <= '0;
			host_out    <= '0;
			irq_mask    <= '0;
			prdata_o    <= 32'h0000_0000;
		end else begin
			port4_latch <= next_port4_latch;
			port4_dir   <= next_port4_dir;
			port5_latch <= next_port5_latch;
			port5_dir   <= next_port5_dir;
			analog_cfg  <= next_analog_cfg;
			host_mode   <= next_host_mode;
			in_full     <= next_in_full;
			out_full    <= next_out_full;
			overrun     <= next_overrun;
			host_in     <= next_host_in;
			host_out    <= next_host_out;
			irq_mask    <= next_irq_mask;
			prdata_o    <= next_prdata;
		end
	end

	dpio_irq u_irq (
		.sys_clk_i (sys_clk_i),
		.rst_i     (rst_i),
		.event_i   ({wr_done && in_full, rd_done, wr_done}),
		.clear_i   (irq_clear),
		.mask_i    (irq_mask),
		.status_o  (irq_status),
		.irq_o     (irq_o)
	);

	property p_host_wr_full;
		@(posedge sys_clk_i) disable iff (rst_i) wr_done |=> in_full;
	endproperty
	a_host_wr_full: assert property (p_host_wr_full) else $error("write not flagged");

	property p_overrun;
		@(posedge sys_clk_i) disable iff (rst_i) (wr_done && in_full) |=> overrun;
	endproperty
	a_overrun: assert property (p_overrun) else $error("overrun missed");

	property p_rd_clears;
		@(posedge sys_clk_i) disable iff (rst_i)
			rd_done && !(wr_acc && hit(paddr_i, `DPIO_IDX_HOST_OUT)) |=> !out_full;
	endproperty
	a_rd_clears: assert property (p_rd_clears) else $error("outbound not cleared");

	property p_gate;
		@(posedge sys_clk_i) disable iff (rst_i)
			(!host_mode || !(&port5_dir) || (analog_cfg != 3'h0)) |-> !wr_done && !rd_done;
	endproperty
	a_gate: assert property (p_gate) else $error("strobe taken while disabled");

	property p_analog_zero;
		@(posedge sys_clk_i) disable iff (rst_i)
			(rd_acc && hit(paddr_i, `DPIO_IDX_PORT5_DATA)) |=>
			((prdata_o[2:0] & analog_cfg) == 3'h0);
	endproperty
	a_analog_zero: assert property (p_analog_zero) else $error("analog pin read nonzero");

	property p_dir_oe;
		@(posedge sys_clk_i) disable iff (rst_i) port5_pins_oe_o == ~port5_dir;
	endproperty
	a_dir_oe: assert property (p_dir_oe) else $error("direction ignored");

	property p_port4_oe;
		@(posedge sys_clk_i) disable iff (rst_i) !host_mode |-> port4_pins_oe_o == ~port4_dir;
	endproperty
	a_port4_oe: assert property (p_port4_oe) else $error("port direction wrong");

	property p_bit3_zero;
		@(posedge sys_clk_i) disable iff (rst_i)
			(rd_acc && hit(paddr_i, `DPIO_IDX_PORT5_DIR)) |=> !prdata_o[3];
	endproperty
	a_bit3_zero: assert property (p_bit3_zero) else $error("bit 3 not zero");

	property p_host_drive;
		@(posedge sys_clk_i) disable iff (rst_i)
			host_mode && !rd_active |-> port4_pins_oe_o == '0;
	endproperty
	a_host_drive: assert property (p_host_drive) else $error("host bus driven");

	c_wr: cover property (@(posedge sys_clk_i) disable iff (rst_i) wr_done);
	c_rd: cover property (@(posedge sys_clk_i) disable iff (rst_i) rd_done);
	c_ovr: cover property (@(posedge sys_clk_i) disable iff (rst_i) wr_done && in_full);
endmodule

// ---- tb/dpio_host_model.sv ----
`timescale 1ns/1ps
// External processor on the byte port. Strobes are active low: bit 0 read,
// bit 1 write, bit 2 select. A released bus shows the inverted last byte,
// so a stale value can never pass for fresh data.
module dpio_host_model (
	input  wire logic       sys_clk_i,
	input  wire logic [7:0] bus_i,
	output logic      [7:0] bus_o,
	output logic      [2:0] ctl_o
);
	logic [7:0] last = 8'h00;
	initial begin
		bus_o = 8'hff;
		ctl_o = 3'h7;
	end
	task automatic drive(input logic [7:0] d);
		last = d;
		bus_o <= d;
	endtask
	task automatic write_byte(input logic [7:0] d, input int hold);
		drive(d);
		ctl_o <= 3'h1;
		repeat (hold) @(posedge sys_clk_i);
		ctl_o <= 3'h7;
		@(posedge sys_clk_i);
		bus_o <= ~last;
		@(posedge sys_clk_i);
	endtask
	task automatic read_byte(input int hold, output logic [7:0] q);
		ctl_o <= 3'h2;
		repeat (hold) @(posedge sys_clk_i);
		q = bus_i;
		ctl_o <= 3'h7;
		@(posedge sys_clk_i);
	endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`include "dpio_defines.svh"
module tb_top;
	localparam logic [7:0] p4a = `DPIO_IDX_PORT4_DATA;
	localparam logic [7:0] p4d = `DPIO_IDX_PORT4_DIR;
	localparam logic [7:0] p5a = `DPIO_IDX_PORT5_DATA;
	localparam logic [7:0] p5d = `DPIO_IDX_PORT5_DIR;
	localparam logic [7:0] anc = `DPIO_IDX_ANALOG_CFG;
	localparam logic [7:0] irs = `DPIO_IDX_IRQ_STATUS;
	localparam logic [7:0] irm = `DPIO_IDX_IRQ_MASK;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic        pready, irq, serr, se;
	logic [2:0]  asel, e5;
	logic [7:0]  p4i, p4o, p4oe, hbus, dir, dat, ext, ob, hb, q;
	logic [2:0]  p5i, p5o, p5oe, hctl, an;
	int          bad_count = 0;
	int          compares = 0;
	int          cyc = 0;
	int          i;
	// Each wire level is taken from the DUT where its enable is set, else from the host.
	assign p4i = (p4oe & p4o) | (~p4oe & hbus);
	assign p5i = (p5oe & p5o) | (~p5oe & hctl);
	dpio_top u_dut (.sys_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
		.pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(serr), .port4_pins_i(p4i), .port4_pins_o(p4o),
		.port4_pins_oe_o(p4oe), .port5_pins_i(p5i), .port5_pins_o(p5o),
		.port5_pins_oe_o(p5oe), .analog_sel_o(asel), .irq_o(irq));
	dpio_host_model u_host (.sys_clk_i(clk), .bus_i(p4i), .bus_o(hbus), .ctl_o(hctl));
	initial begin
		forever #50 clk = ~clk;
	end
	function automatic logic [7:0] pins(input logic [7:0] d, l, e);
		return (~d & l) | (d & e);
	endfunction
	task automatic chk(input string n, input logic [31:0] e, g);
		compares++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= {2'b00, a, 2'b00};
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		// Only the cycle ceiling ends a wait that never sees ready.
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd = prdata;
		se = serr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(n, e, rd);
	endtask
	task automatic complete_run();
		$display("compares %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			bad_count++;
			complete_run();
		end
	end
	initial begin
		void'($urandom(32'h709d_ff17));
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rchk("p4dir", p4d, 32'h0000_00ff);
		rchk("p5dir", p5d, 32'h0000_0007);
		rchk("analog", anc, 32'h0000_0007);
		rchk("p5pins", p5a, 32'h0000_0000);
		rchk("unmapped", 8'h3c, 32'h0000_0000);
		chk("slverr", 32'h0000_0000, {31'h0, se});
		chk("p4oe", 32'h0000_0000, 32'(p4oe));
		chk("asel", 32'h0000_0007, {29'h0, asel});
		$display("test reset done");
		for (i = 0; i < 6; i++) begin
			dir = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
			dat = 8'($urandom);
			ext = 8'($urandom);
			u_host.drive(ext);
			apb(1'b1, p4d, 32'(dir));
			apb(1'b1, p4a, 32'(dat));
			chk("p4oe", {24'h0, ~dir}, 32'(p4oe));
			chk("p4out", 32'(dat & ~dir), 32'(p4o & ~dir));
			rchk("p4pins", p4a, 32'(pins(dir, dat, ext)));
		end
		$display("test port4 done");
		for (i = 0; i < 8; i++) begin
			an = 3'($urandom);
			dat = 8'($urandom);
			apb(1'b1, anc, 32'(an));
			apb(1'b1, p5d, 32'(i));
			apb(1'b1, p5a, 32'(dat));
			chk("p5oe", {29'h0, ~3'(i)}, 32'(p5oe));
			chk("asel", {29'h0, an}, {29'h0, asel});
			e5 = 3'(pins(8'(i), dat, 8'hff)) & ~an;
			rchk("p5pins", p5a, {29'h0, e5});
		end
		$display("test port5 done");
		apb(1'b1, anc, 32'h0000_0000);
		apb(1'b1, p5d, 32'h0000_0017);
		apb(1'b1, irm, 32'h0000_0007);
		ob = 8'($urandom);
		hb = 8'($urandom);
		apb(1'b1, `DPIO_IDX_HOST_OUT, 32'(ob));
		rchk("outfull", p5d, 32'h0000_0057);
		u_host.write_byte(hb, 2);
		rchk("infull", p5d, 32'h0000_00d7);
		rchk("inbyte", `DPIO_IDX_HOST_IN, 32'(hb));
		rchk("inread", p5d, 32'h0000_0057);
		u_host.write_byte(~hb, 3);
		u_host.write_byte(hb, 2);
		rchk("overrun", p5d, 32'h0000_00f7);
		apb(1'b1, p5d, 32'h0000_003f);
		rchk("flagsro", p5d, 32'h0000_00f7);
		apb(1'b1, p5d, 32'h0000_00d7);
		rchk("ovclear", p5d, 32'h0000_00d7);
		rchk("status", irs, 32'h0000_0005);
		chk("irqon", 32'h0000_0001, 32'(irq));
		apb(1'b1, irm, 32'h0000_0000);
		@(posedge clk);
		chk("irqmask", 32'h0000_0000, 32'(irq));
		u_host.read_byte(3, q);
		chk("outbyte", 32'(ob), 32'(q));
		rchk("outread", p5d, 32'h0000_0097);
		apb(1'b1, irs, 32'h0000_0007);
		rchk("w1c", irs, 32'h0000_0000);
		$display("test host done");
		apb(1'b0, `DPIO_IDX_HOST_IN, 32'h0000_0000);
		apb(1'b1, anc, 32'h0000_0007);
		u_host.write_byte(hb, 2);
		rchk("analogon", p5d, 32'h0000_0017);
		apb(1'b1, anc, 32'h0000_0000);
		apb(1'b1, p5d, 32'h0000_0013);
		u_host.write_byte(hb, 2);
		rchk("dirout", p5d, 32'h0000_0013);
		apb(1'b1, p5d, 32'h0000_0007);
		u_host.write_byte(hb, 2);
		rchk("modeoff", p5d, 32'h0000_0007);
		$display("test refusal done");
		complete_run();
	end
endmodule
